/* File: slot_gate_consts.vh */
`ifndef SLOT_GATE_CONSTS_VH
`define SLOT_GATE_CONSTS_VH

// Clock and divider
`define CLK_HZ              25000000
`define PULSE_DIV           4
`define SLOT_COUNT          8
`define SLOT_BITS           3

// Emission mask
`define MASK_RESET          8'hff

// Lock register codes
`define LOCK_CODE           8'hca
`define UNLOCK_CODE         8'h9c

// Primary status layout
`define STAT_RESET_BIT      0
// Configuration layout
`define CFG_CLKOUT_BIT      0
`define CFG_RESET           8'h00

// Timing
`define RESET_BUSY_MS       20
`define READY_LOW_CYCLES    64

`endif

/* File: slot_pulse_gen.v */
`timescale 1ns/100ps
`default_nettype none
`include "slot_gate_consts.vh"

// Divide-by-four pulse engine with eight mask-gated slots
module slot_pulse_gen (
	input  wire       clk_i,
	input  wire       rst_i,
	input  wire       run_i,
	input  wire [7:0] mask_i,
	output wire       pulse_o,
	output wire [2:0] slot_o,
	output wire       div_clk_o
);
	reg [1:0] div_ff;
	reg [1:0] nxt_div;
	reg       pulse_ff;
	reg [2:0] slot_ff;
	reg       div_clk_ff;

	// ------------------------------------------------------------
	// Divider and slot sequencing
	// ------------------------------------------------------------
	always @* begin
		nxt_div = div_ff + 2'd1;
	end

	// Every half period of the divided clock offers one slot
	always @(posedge clk_i) begin
		if (rst_i || !run_i) begin
			div_ff     <= 2'd0;
			slot_ff    <= 3'd0;
			pulse_ff   <= 1'b0;
			div_clk_ff <= 1'b0;
		end else begin
			div_ff     <= nxt_div;
			div_clk_ff <= nxt_div[1];
			// Mask sampled only at the opportunity, so a pulse never tears
			if (div_ff[0]) begin
				pulse_ff <= mask_i[slot_ff];
				slot_ff  <= slot_ff + 3'd1;
			end else begin
				pulse_ff <= 1'b0;
			end
		end
	end

	// Outputs straight from the flip-flops
	assign pulse_o   = pulse_ff;
	assign slot_o    = slot_ff;
	assign div_clk_o = div_clk_ff;
endmodule
`default_nettype wire

/* File: isolated_supply_ctrl.v */
// Behaviour
// - Pulse engine runs at input clock over four, one pulse per half period.
// - Eight slots, zero to seven, cycle continuously in order.
// - Mask bit n gates slot n.
// - Mask bit one emits, zero suppresses; mask resets to all ones.
// - Reset-in-progress bit clears about 20 ms after start; host polls it.
// - Writing 0xca to lock protects configuration registers.
// - Data-ready strobe low for 64 input clock cycles on new results.
// - Shared pin defaults to data-ready after reset.
// - Writing 0x9c to lock removes protection.
// - Pin shows data-ready when clock enable is zero, clock otherwise.
`timescale 1ns/100ps
`default_nettype none
`include "slot_gate_consts.vh"

module isolated_supply_ctrl #(
	parameter integer BUSY_CYCLES = `CLK_HZ / 1000 * `RESET_BUSY_MS
) (
	input  wire       clk_i,
	input  wire       rst_i,
	input  wire       mask_wr_i,
	input  wire [7:0] mask_data_i,
	input  wire       cfg_wr_i,
	input  wire [7:0] cfg_data_i,
	input  wire       lock_wr_i,
	input  wire [7:0] lock_data_i,
	input  wire       result_ready_i,
	output wire [7:0] emission_slot_mask_o,
	output wire [7:0] config_o,
	output wire [7:0] primary_status_o,
	output wire       locked_o,
	output wire       clock_or_ready_pin_o,
	output wire       pwm_pulse_o,
	output wire [2:0] slot_o
);
	// Last count of the data-ready strobe; kept as an integer so no bits are lost
	localparam integer READY_LAST = `READY_LOW_CYCLES - 1;

	// ------------------------------------------------------------
	// Internal state
	// ------------------------------------------------------------
	// Start-up timer; 32 bits cover the full 20 ms at any sane clock
	reg        busy_ff;
	reg [31:0] busy_cnt_ff;
	reg        nxt_busy;
	reg [31:0] nxt_busy_cnt;
	// Programmable registers and their protection
	reg [7:0]  mask_ff;
	reg [7:0]  config_ff;
	reg        locked_ff;
	reg [7:0]  nxt_mask;
	reg [7:0]  nxt_config;
	reg        nxt_locked;
	// Lock code decode
	wire       lock_hit;
	wire       unlock_hit;
	wire       writable;
	// Data-ready strobe
	reg        ready_active_ff;
	reg [5:0]  ready_cnt_ff;
	reg        nxt_ready_active;
	reg [5:0]  nxt_ready_cnt;
	wire       ready_last;
	// Shared pin
	reg        pin_ff;
	reg        nxt_pin;
	wire       clk_out_sel;
	wire       div_clk;

	// ------------------------------------------------------------
	// Start-up busy timer
	// ------------------------------------------------------------
	// Count start-up cycles; the count freezes once the flag drops,
	// so a long-running part never wraps back into reset-in-progress
	always @* begin
		nxt_busy     = busy_ff;
		nxt_busy_cnt = busy_cnt_ff;
		if (busy_ff) begin
			if (busy_cnt_ff >= BUSY_CYCLES - 1)
				nxt_busy = 1'b0;
			else
				nxt_busy_cnt = busy_cnt_ff + 32'h0000_0001;
		end
	end

	// Reset-in-progress stays set until the busy count expires
	always @(posedge clk_i) begin
		if (rst_i) begin
			busy_ff     <= 1'b1;
			busy_cnt_ff <= 32'h0000_0000;
		end else begin
			busy_ff     <= nxt_busy;
			busy_cnt_ff <= nxt_busy_cnt;
		end
	end

	// Only reset-in-progress is live; the other status bits read as zero
	assign primary_status_o = {7'h00, busy_ff};

	// ------------------------------------------------------------
	// Configuration registers and protection
	// ------------------------------------------------------------
	// Only the two lock codes move the lock; any other value is ignored,
	// so a stray write cannot half-open the protection
	assign lock_hit   = lock_wr_i && (lock_data_i == `LOCK_CODE);
	assign unlock_hit = lock_wr_i && (lock_data_i == `UNLOCK_CODE);
	// A write in the same cycle as a lock code still sees the old lock state
	assign writable   = !locked_ff;

	// Next values; writes are dropped while locked, lock always writable
	always @* begin
		nxt_locked = locked_ff;
		nxt_mask   = mask_ff;
		nxt_config = config_ff;
		if (lock_hit)
			nxt_locked = 1'b1;
		else if (unlock_hit)
			nxt_locked = 1'b0;
		if (mask_wr_i && writable)
			nxt_mask = mask_data_i;
		if (cfg_wr_i && writable)
			nxt_config = cfg_data_i;
	end

	// Registers come up unlocked, all slots enabled, pin on data-ready
	always @(posedge clk_i) begin
		if (rst_i) begin
			mask_ff   <= `MASK_RESET;
			config_ff <= `CFG_RESET;
			locked_ff <= 1'b0;
		end else begin
			mask_ff   <= nxt_mask;
			config_ff <= nxt_config;
			locked_ff <= nxt_locked;
		end
	end

	// Register copies are the data outputs, straight from flip-flops
	assign emission_slot_mask_o = mask_ff;
	assign config_o             = config_ff;
	assign locked_o             = locked_ff;

	// ------------------------------------------------------------
	// Pulse engine, held idle while reset is in progress
	// ------------------------------------------------------------
	slot_pulse_gen u_pulse (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.run_i     (!busy_ff),
		.mask_i    (emission_slot_mask_o),
		.pulse_o   (pwm_pulse_o),
		.slot_o    (slot_o),
		.div_clk_o (div_clk)
	);

	// ------------------------------------------------------------
	// Data-ready strobe and shared pin
	// ------------------------------------------------------------
	// Strobe ends when the counter reaches its last count
	assign ready_last = ({26'd0, ready_cnt_ff} == READY_LAST);

	// Fixed 64-cycle low strobe; a new result during a strobe restarts it,
	// so a host that reacts late still sees one full-length strobe
	always @* begin
		nxt_ready_active = ready_active_ff;
		nxt_ready_cnt    = ready_cnt_ff;
		if (result_ready_i) begin
			nxt_ready_active = 1'b1;
			nxt_ready_cnt    = 6'd0;
		end else if (ready_active_ff) begin
			if (ready_last)
				nxt_ready_active = 1'b0;
			else
				nxt_ready_cnt = ready_cnt_ff + 6'd1;
		end
	end

	// Strobe state
	always @(posedge clk_i) begin
		if (rst_i) begin
			ready_active_ff <= 1'b0;
			ready_cnt_ff    <= 6'd0;
		end else begin
			ready_active_ff <= nxt_ready_active;
			ready_cnt_ff    <= nxt_ready_cnt;
		end
	end

	// Clock output enable picks what the shared pin shows
	assign clk_out_sel = config_ff[`CFG_CLKOUT_BIT];

	// Pin source select; the ready strobe is active low
	always @* begin
		if (clk_out_sel)
			nxt_pin = div_clk;
		else
			nxt_pin = !ready_active_ff;
	end

	// Pin mux registered to keep it glitch free, at one cycle of latency
	always @(posedge clk_i) begin
		if (rst_i)
			pin_ff <= 1'b1;
		else
			pin_ff <= nxt_pin;
	end

	// Pin output straight from its flip-flop
	assign clock_or_ready_pin_o = pin_ff;
endmodule
`default_nettype wire

/* File: supply_checker.sv */
`timescale 1ns/100ps
`default_nettype none
// Port watcher; slot and lock relations
module supply_checker (
	input wire       clk_i,
	input wire       rst_i,
	input wire       mask_wr_i,
	input wire       lock_wr_i,
	input wire       result_ready_i,
	input wire       locked_o,
	input wire       clock_or_ready_pin_o,
	input wire       pwm_pulse_o,
	input wire [7:0] mask_data_i,
	input wire [7:0] lock_data_i,
	input wire [7:0] emission_slot_mask_o,
	input wire [7:0] config_o,
	input wire [2:0] slot_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	AST_STEP: assert property ($changed(slot_o) |-> slot_o == $past(slot_o) + 3'h1) else $error("slot");
	AST_RATE: assert property ($changed(slot_o) |=> $stable(slot_o) ##1 $changed(slot_o)) else $error("rate");
	AST_GATE: assert property (pwm_pulse_o |-> $past(emission_slot_mask_o[slot_o])) else $error("gate");
	AST_KEEP: assert property (locked_o && mask_wr_i |=> $stable(emission_slot_mask_o)) else $error("kept");
	AST_TAKE: assert property (!locked_o && mask_wr_i |=> emission_slot_mask_o == $past(mask_data_i))
		else $error("take");
	AST_LOCK: assert property (lock_wr_i && lock_data_i == 8'hca |=> locked_o) else $error("lock");
	AST_FREE: assert property (lock_wr_i && lock_data_i == 8'h9c |=> !locked_o) else $error("free");
	AST_READY: assert property (result_ready_i && !config_o[0] |=> ##1 !clock_or_ready_pin_o)
		else $error("ready");
endmodule
bind isolated_supply_ctrl supply_checker supply_checker_i(.*);
`default_nettype wire

/* File: host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Host: polls busy, then programs and locks
module host_model (
	input  wire        clk_i,
	input  wire  [7:0] primary_status_o,
	output logic       mask_wr_i,
	output logic       cfg_wr_i,
	output logic       lock_wr_i,
	output logic [7:0] mask_data_i,
	output logic [7:0] cfg_data_i,
	output logic [7:0] lock_data_i
);
	initial {mask_wr_i, cfg_wr_i, lock_wr_i, mask_data_i, cfg_data_i, lock_data_i} = 27'h0;
	// Released data flips so a stale value never looks valid
	task wr(input int s, input logic [7:0] d);
		@(posedge clk_i); #1;
		{mask_wr_i, cfg_wr_i, lock_wr_i} = 3'b100 >> s;
		{mask_data_i, cfg_data_i, lock_data_i} = {3{d}};
		@(posedge clk_i); #1;
		{mask_wr_i, cfg_wr_i, lock_wr_i, mask_data_i, cfg_data_i, lock_data_i} = {3'h0, {3{~d}}};
	endtask
	task init(output bit ok);
		ok = 0;
		// Status is read just after the edge, once the design has settled it
		for (int i = 0; i < 200 && !ok; i++) begin
			@(posedge clk_i);
			#1;
			ok = primary_status_o[0] === 1'b0;
		end
		if (ok) begin
			wr(1, 8'h00); // Ready on pin
			wr(0, 8'h55); // Lone device: no sync needed
			wr(2, 8'hca);
		end
	endtask
endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic clk_i = 0, rst_i = 1, result_ready_i = 0, mask_wr_i, cfg_wr_i, lock_wr_i, locked_o, clock_or_ready_pin_o;
	logic pwm_pulse_o;
	logic [7:0] mask_data_i, cfg_data_i, lock_data_i, emission_slot_mask_o, config_o, primary_status_o, m, e;
	logic [2:0] slot_o;
	logic [31:0] r = 32'd93175;
	int fails = 0, n_compared = 0, low = 0, pulses = 0, rises = 0, q[$];
	bit ok;
	// Random source for mask values
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	isolated_supply_ctrl #(.BUSY_CYCLES(20)) isolated_supply_ctrl_i(.*);
	host_model host_model_i(.*);
	initial forever #20 clk_i = ~clk_i;
	task chk(input logic [7:0] s, x);
		n_compared++;
		if (s !== x) begin fails++; $display("Error %0t: saw %h want %h", $time, s, x); end
	endtask
	task conclude;
		$display("compared %0d failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Skip two edges so a pulse sampled before the write is not counted
	task count;
		repeat (2) @(posedge clk_i); #1 pulses = 0; rises = 0; repeat (64) @(posedge clk_i); #1;
	endtask
	// Monitor on falling edge, where outputs are settled
	always @(negedge clk_i) begin
		pulses += pwm_pulse_o;
		if (!clock_or_ready_pin_o) low++;
		else if (low > 0) begin
			rises++;
			if (!config_o[0]) chk(8'(low), q.size() ? 8'(q.pop_front()) : 8'hee);
			low = 0;
		end
	end
	initial begin
		repeat (10) @(posedge clk_i); #1 rst_i = 0;
		chk(primary_status_o, 8'h01);
		chk(emission_slot_mask_o, 8'hff);
		chk({7'h0, clock_or_ready_pin_o}, 8'h01);
		host_model_i.init(ok);
		if (!ok) begin
			fails++;
		end else begin
			chk(primary_status_o, 8'h00);
			chk({7'h0, locked_o}, 8'h01);
			count; chk(8'(pulses), 8'd16);
			q.push_back(64); result_ready_i = 1; @(posedge clk_i); #1 result_ready_i = 0;
			e = 8'h55;
			repeat (3) begin
				r = lfsr(r); m = r[7:0];
				host_model_i.wr(0, m); chk(emission_slot_mask_o, e);
				host_model_i.wr(2, 8'h9c); host_model_i.wr(0, m); chk(emission_slot_mask_o, m);
				count; chk(8'(pulses), 8'($countones(m) * 4));
				host_model_i.wr(2, 8'hca); e = m;
			end
			host_model_i.wr(2, 8'h9c); host_model_i.wr(1, 8'h01);
			count; chk(8'(rises), 8'd16);
			chk(8'(q.size()), 8'h00);
		end
		conclude;
	end
endmodule
`default_nettype wire
